// ### logic/atc_cfg.svh
`ifndef ATC_CFG_SVH
`define ATC_CFG_SVH

// register offsets on the device register port
`define ATC_SETUP1_ADDR    8'h0b
`define ATC_SETUP2_ADDR    8'h0e
`define ATC_CONFIG_ADDR    8'h0f

// reset values
`define ATC_SETUP_RESET    8'h0b
`define ATC_CONFIG_RESET   8'h19
`define ATC_UNMAPPED_READ  8'h00

// setup register fields
`define ATC_SET_RANGE_HI   7
`define ATC_SET_RANGE_LO   6
`define ATC_SET_HYST_DIS   4
`define ATC_SET_SETTLE_MSB 3
`define ATC_SET_SETTLE_LSB 0

// configuration register fields
`define ATC_CFG_FIXED      7
`define ATC_CFG_CMP_HI     6
`define ATC_CFG_CMP_LO     5
`define ATC_CFG_EN_CH1     4
`define ATC_CFG_EN_CH2     3
`define ATC_CFG_MODE_MSB   2
`define ATC_CFG_MODE_LSB   0

// averaging and hysteresis arithmetic
`define ATC_FRAC_BITS      16
`define ATC_HYST_SHIFT     2

`endif

// ### logic/atc_pkg.sv
`default_nettype none
package atc_pkg;

   // output comparator condition
   typedef enum logic [1:0] {
      ATC_CMP_NEG  = 2'b00,
      ATC_CMP_POS  = 2'b01,
      ATC_CMP_IN   = 2'b10,
      ATC_CMP_OUT  = 2'b11
   } atc_cmp_e;

   typedef logic [15:0] atc_data_t;  // converter result
   typedef logic [7:0]  atc_reg_t;   // register byte

endpackage
`default_nettype wire

// ### logic/atc_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "atc_cfg.svh"

module atc_channel (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             conv_valid,      // one result for this channel
   input  wire atc_pkg::atc_data_t conv_data,
   input  wire logic [3:0]       settle_code,
   input  wire logic             hyst_disable,
   input  wire logic             fixed_select,
   input  wire logic [1:0]       compare_mode,
   input  wire atc_pkg::atc_data_t sensitivity,
   input  wire atc_pkg::atc_data_t fixed_threshold,
   output atc_pkg::atc_data_t    average,
   output logic                  detect
);

   logic [31:0]        acc_q;       // average, 16.16 fixed point
   logic [31:0]        acc_d;
   logic               seeded_q;    // first result taken
   logic               detect_q;
   logic               detect_d;
   logic signed [32:0] diff;
   logic signed [32:0] step;
   logic [4:0]         shamt;
   logic signed [18:0] data_s, avg_s, sens_s, thr_s, hy_s, lo_s, hi_s;
   logic               hyst_on;

   // exponential average step, divide by 2^(code+1)
   always_comb begin
      shamt = {1'b0, settle_code} + 5'd1;
      diff  = $signed({1'b0, conv_data, 16'h0000}) - $signed({1'b0, acc_q});
      step  = diff >>> shamt;
      acc_d = acc_q + step[31:0];
   end

   // average register; first result seeds it so start-up has no long ramp
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         acc_q    <= 32'h0000_0000;
         seeded_q <= 1'b0;
      end else if (conv_valid) begin
         seeded_q <= 1'b1;
         if (seeded_q) begin
            acc_q <= acc_d;
         end else begin
            acc_q <= {conv_data, 16'h0000};
         end
      end
   end

   assign average = acc_q[31:16];

   // thresholds; wide signed math so avg +/- sensitivity never wraps
   always_comb begin
      // one spare bit so hi + hysteresis cannot wrap at full scale either
      data_s  = $signed({3'b000, conv_data});
      avg_s   = $signed({3'b000, acc_q[31:16]});
      sens_s  = $signed({3'b000, sensitivity});
      thr_s   = $signed({3'b000, fixed_threshold});
      // fixed mode never holds back the release
      hyst_on = !fixed_select && !hyst_disable;
      hy_s    = (hyst_on && detect_q) ?
                $signed({3'b000, sensitivity >> `ATC_HYST_SHIFT}) : 19'sd0;
      if (fixed_select) begin
         lo_s = thr_s;
         hi_s = thr_s;
      end else begin
         lo_s = avg_s - sens_s;
         hi_s = avg_s + sens_s;
      end
   end

   // output condition; an active output widens its own band by hy_s
   always_comb begin
      unique case (atc_pkg::atc_cmp_e'(compare_mode))
         atc_pkg::ATC_CMP_NEG: detect_d = data_s < lo_s + hy_s;
         atc_pkg::ATC_CMP_POS: detect_d = data_s > hi_s - hy_s;
         atc_pkg::ATC_CMP_IN:  detect_d = (data_s > lo_s - hy_s) && (data_s < hi_s + hy_s);
         atc_pkg::ATC_CMP_OUT: detect_d = (data_s < lo_s + hy_s) || (data_s > hi_s - hy_s);
      endcase
   end

   // detection flag, refreshed once per result
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         detect_q <= 1'b0;
      end else if (conv_valid) begin
         detect_q <= detect_d;
      end
   end

   assign detect = detect_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   logic signed [32:0] half_step;  // helper: expected change for code 0
   assign half_step = diff >>> 1;

   chk_avg_half_step: assert property (
      conv_valid && seeded_q && settle_code == 4'h0
      |=> acc_q == $past(acc_q) + $past(half_step[31:0]))
      else $error("average step wrong for settling code 0");
   chk_avg_slow_code: assert property (
      conv_valid && seeded_q && settle_code == 4'hf && conv_data == acc_q[31:16]
      |=> acc_q[31:16] == $past(acc_q[31:16]))
      else $error("average moved on a matching result");
   chk_fixed_assert: assert property (
      conv_valid && fixed_select && compare_mode == 2'b01
      && conv_data > fixed_threshold |=> detect)
      else $error("fixed positive compare missed");
   chk_fixed_no_hyst: assert property (
      conv_valid && fixed_select && !hyst_disable && compare_mode == 2'b00
      && conv_data >= fixed_threshold |=> !detect)
      else $error("hysteresis held output in fixed mode");
   chk_adapt_neg: assert property (
      conv_valid && !fixed_select && compare_mode == 2'b00
      && data_s < avg_s - sens_s |=> detect)
      else $error("adaptive negative compare missed");
   chk_hyst_off: assert property (
      conv_valid && !fixed_select && hyst_disable && compare_mode == 2'b00
      && data_s >= avg_s - sens_s |=> !detect)
      else $error("hysteresis applied while disabled");
   chk_hyst_hold: assert property (
      conv_valid && !fixed_select && !hyst_disable && detect_q && compare_mode == 2'b00
      && data_s < avg_s - sens_s + $signed({2'b00, sensitivity >> `ATC_HYST_SHIFT})
      |=> detect)
      else $error("hysteresis did not hold output");
   chk_out_window: assert property (
      conv_valid && !fixed_select && compare_mode == 2'b11
      && data_s > avg_s + sens_s ##1 !conv_valid |-> detect)
      else $error("out-window compare missed");

   cov_detect_rise: cover property (conv_valid ##1 $rose(detect));
   cov_fixed_conv:  cover property (conv_valid && fixed_select);

endmodule
`default_nettype wire

// ### logic/atc_top.sv
// Operation
// - hysteresis-disable bit turns hysteresis off, adaptive mode
// - fixed mode never applies hysteresis
// - average moves by difference over 2^(code+1)
// - time constant 2 to 65536 conversions
// - configuration at 0x0F, preset 0x19
// - fixed mode compares against fixed threshold
// - adaptive mode compares against running average limits
// - compare mode picks negative, positive, window conditions
// - setup registers 0x0B, 0x0E, settling preset 0x0B
`timescale 1ns/1ps
`default_nettype none
`include "atc_cfg.svh"

module atc_top (
   input  wire logic               mclk,
   input  wire logic               rst,
   // register port, driven by the serial interface logic on mclk
   input  wire logic [7:0]         reg_addr,
   input  wire atc_pkg::atc_reg_t  reg_wdata,
   input  wire logic               reg_we,
   input  wire logic               reg_re,
   output atc_pkg::atc_reg_t       reg_rdata,
   // converter results, same clock domain
   input  wire logic               conv_done,
   input  wire logic               conv_channel,
   input  wire atc_pkg::atc_data_t conv_data,
   // per-channel limits from registers kept elsewhere
   input  wire atc_pkg::atc_data_t sensitivity_ch1,
   input  wire atc_pkg::atc_data_t sensitivity_ch2,
   input  wire atc_pkg::atc_data_t fixed_threshold_ch1,
   input  wire atc_pkg::atc_data_t fixed_threshold_ch2,
   // results
   output atc_pkg::atc_data_t      average_ch1,
   output atc_pkg::atc_data_t      average_ch2,
   output logic [1:0]              detect_out,
   // controls toward the converter
   output logic                    channel_one_enable,
   output logic                    channel_two_enable,
   output logic [2:0]              conversion_mode,
   output logic [1:0]              range_ch1,
   output logic [1:0]              range_ch2
);

   atc_pkg::atc_reg_t setup_q [2];                  // channel setup bytes
   atc_pkg::atc_reg_t threshold_and_conversion_config_q;
   atc_pkg::atc_reg_t rdata_q;                      // read data flop

   logic                fixed_threshold_select;
   logic                compare_mode_hi;
   logic                compare_mode_lo;
   logic [1:0]          chan_en;
   atc_pkg::atc_data_t  sens [2];
   atc_pkg::atc_data_t  thr [2];
   atc_pkg::atc_data_t  avg [2];

   // address of a channel's setup register
   function automatic logic [7:0] setup_addr(input int ch);
      setup_addr = (ch == 0) ? `ATC_SETUP1_ADDR : `ATC_SETUP2_ADDR;
   endfunction

   // setup registers; bit 5 stored as written, its effect is left open
   for (genvar g = 0; g < 2; g++) begin : g_setup
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            setup_q[g] <= `ATC_SETUP_RESET;
         end else if (reg_we && reg_addr == setup_addr(g)) begin
            setup_q[g] <= reg_wdata;
         end
      end
   end

   // configuration register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         threshold_and_conversion_config_q <= `ATC_CONFIG_RESET;
      end else if (reg_we && reg_addr == `ATC_CONFIG_ADDR) begin
         threshold_and_conversion_config_q <= reg_wdata;
      end
   end

   // read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_q <= `ATC_UNMAPPED_READ;
      end else if (reg_re) begin
         if (reg_addr == setup_addr(0)) begin
            rdata_q <= setup_q[0];
         end else if (reg_addr == setup_addr(1)) begin
            rdata_q <= setup_q[1];
         end else if (reg_addr == `ATC_CONFIG_ADDR) begin
            rdata_q <= threshold_and_conversion_config_q;
         end else begin
            rdata_q <= `ATC_UNMAPPED_READ;
         end
      end
   end

   // read data straight from its flop, held until the next read
   assign reg_rdata = rdata_q;

   // configuration fields
   assign fixed_threshold_select = threshold_and_conversion_config_q[`ATC_CFG_FIXED];
   assign compare_mode_hi        = threshold_and_conversion_config_q[`ATC_CFG_CMP_HI];
   assign compare_mode_lo        = threshold_and_conversion_config_q[`ATC_CFG_CMP_LO];
   assign channel_one_enable     = threshold_and_conversion_config_q[`ATC_CFG_EN_CH1];
   assign channel_two_enable     = threshold_and_conversion_config_q[`ATC_CFG_EN_CH2];
   assign conversion_mode        =
      threshold_and_conversion_config_q[`ATC_CFG_MODE_MSB:`ATC_CFG_MODE_LSB];
   assign range_ch1 = setup_q[0][`ATC_SET_RANGE_HI:`ATC_SET_RANGE_LO];
   assign range_ch2 = setup_q[1][`ATC_SET_RANGE_HI:`ATC_SET_RANGE_LO];
   assign chan_en   = {channel_two_enable, channel_one_enable};

   // per-channel limits gathered so the generate loop can index them
   assign sens[0] = sensitivity_ch1;
   assign sens[1] = sensitivity_ch2;
   assign thr[0]  = fixed_threshold_ch1;
   assign thr[1]  = fixed_threshold_ch2;

   // one filter per channel; a result for a disabled channel is dropped
   for (genvar g = 0; g < 2; g++) begin : g_chan
      atc_channel u_chan (
         .mclk            (mclk),
         .rst             (rst),
         .conv_valid      (conv_done && conv_channel == 1'(g) && chan_en[g]),
         .conv_data       (conv_data),
         .settle_code     (setup_q[g][`ATC_SET_SETTLE_MSB:`ATC_SET_SETTLE_LSB]),
         .hyst_disable    (setup_q[g][`ATC_SET_HYST_DIS]),
         .fixed_select    (fixed_threshold_select),
         .compare_mode    ({compare_mode_hi, compare_mode_lo}),
         .sensitivity     (sens[g]),
         .fixed_threshold (thr[g]),
         .average         (avg[g]),
         .detect          (detect_out[g])
      );
   end

   // filter outputs back onto the named ports
   assign average_ch1 = avg[0];
   assign average_ch2 = avg[1];

   // checks sample on mclk and stay quiet while reset is high
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // presets seen at the first edge after reset lets go
   chk_reset_preset: assert property (
      $fell(rst) |-> threshold_and_conversion_config_q == `ATC_CONFIG_RESET
      && setup_q[0] == `ATC_SETUP_RESET && setup_q[1] == `ATC_SETUP_RESET
      && reg_rdata == `ATC_UNMAPPED_READ)
      else $error("register presets wrong after reset");

   // a configuration write lands the cycle after
   chk_cfg_write: assert property (
      reg_we && reg_addr == 8'h0f |=> threshold_and_conversion_config_q == $past(reg_wdata))
      else $error("configuration write not stored");

   // configuration changes only by its own write
   chk_cfg_hold: assert property (
      !(reg_we && reg_addr == `ATC_CONFIG_ADDR)
      |=> $stable(threshold_and_conversion_config_q))
      else $error("configuration changed without write");

   // configuration read returns the value before any same-cycle write
   chk_cfg_readback: assert property (
      reg_re && reg_addr == 8'h0f |=> reg_rdata == $past(threshold_and_conversion_config_q))
      else $error("configuration read wrong");

   // channel 1 setup write lands the cycle after
   chk_setup1_write: assert property (
      reg_we && reg_addr == `ATC_SETUP1_ADDR |=> setup_q[0] == $past(reg_wdata))
      else $error("channel 1 setup write lost");

   // channel 2 setup write still held two quiet cycles later
   chk_setup_write: assert property (
      reg_we && reg_addr == 8'h0e ##1 !reg_we [*2] |-> setup_q[1] == $past(reg_wdata, 2))
      else $error("channel 2 setup write lost");

   // channel 1 setup changes only by its own write
   chk_setup_hold: assert property (
      !(reg_we && reg_addr == 8'h0b) |=> $stable(setup_q[0]))
      else $error("channel 1 setup changed without write");

   // channel 2 setup changes only by its own write
   chk_setup2_hold: assert property (
      !(reg_we && reg_addr == `ATC_SETUP2_ADDR) |=> $stable(setup_q[1]))
      else $error("channel 2 setup changed without write");

   // channel 1 setup readback
   chk_setup1_readback: assert property (
      reg_re && reg_addr == `ATC_SETUP1_ADDR |=> reg_rdata == $past(setup_q[0]))
      else $error("channel 1 setup read wrong");

   // channel 2 setup readback
   chk_setup2_readback: assert property (
      reg_re && reg_addr == `ATC_SETUP2_ADDR |=> reg_rdata == $past(setup_q[1]))
      else $error("channel 2 setup read wrong");

   // read data stands until the next read strobe
   chk_rdata_hold: assert property (
      !reg_re |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   // any address outside the map reads as zero
   chk_unmapped: assert property (
      reg_re && reg_addr != `ATC_SETUP1_ADDR && reg_addr != `ATC_SETUP2_ADDR
      && reg_addr != `ATC_CONFIG_ADDR |=> reg_rdata == `ATC_UNMAPPED_READ)
      else $error("unmapped read not zero");

   // a result for disabled channel 1 leaves its outputs alone
   chk_drop_ch1: assert property (
      conv_done && !conv_channel && !channel_one_enable
      |=> $stable(average_ch1) && $stable(detect_out[0]))
      else $error("disabled channel 1 took a result");

   // a result for disabled channel 2 leaves its outputs alone
   chk_drop_ch2: assert property (
      conv_done && conv_channel && !channel_two_enable
      |=> $stable(average_ch2) && $stable(detect_out[1]))
      else $error("disabled channel 2 took a result");

   cov_cfg_write: cover property (reg_we && reg_addr == 8'h0f ##1 fixed_threshold_select);
   cov_both_detect: cover property (detect_out == 2'b11);
   cov_drop_result: cover property (conv_done && !chan_en[conv_channel]);

endmodule
`default_nettype wire

// ### verif/atc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "atc_cfg.svh"

module atc_top_tb;
   logic                mclk;         // 100 MHz
   logic                rst;          // async, active high
   logic [7:0]          reg_addr;
   atc_pkg::atc_reg_t   reg_wdata;
   logic                reg_we;
   logic                reg_re;
   atc_pkg::atc_reg_t   reg_rdata;
   logic                conv_done;
   logic                conv_channel;
   atc_pkg::atc_data_t  conv_data;
   atc_pkg::atc_data_t  sens[2];      // sensitivity per channel
   atc_pkg::atc_data_t  thr[2];       // fixed threshold per channel
   atc_pkg::atc_data_t  avg[2];       // averages seen
   logic [1:0]          detect_out;
   logic                en1;
   logic                en2;
   logic [2:0]          cmode;
   logic [1:0]          rng[2];
   int                  n_mismatch;
   int                  check_count;
   int                  cycles;       // timeout counter
   integer              seed;
   longint              acc[2];       // model average, 16.16
   bit                  act[2];       // model detect state
   bit                  seeded[2];    // first result seeds the average
   atc_pkg::atc_reg_t   cfg;          // model config copy
   atc_pkg::atc_reg_t   setup[2];     // model setup copies
   atc_pkg::atc_reg_t   rd;
   int                  v;
   int                  k;

   atc_top atc_top_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .conv_done(conv_done),
      .conv_channel(conv_channel), .conv_data(conv_data), .sensitivity_ch1(sens[0]),
      .sensitivity_ch2(sens[1]), .fixed_threshold_ch1(thr[0]), .fixed_threshold_ch2(thr[1]),
      .average_ch1(avg[0]), .average_ch2(avg[1]), .detect_out(detect_out),
      .channel_one_enable(en1), .channel_two_enable(en2), .conversion_mode(cmode),
      .range_ch1(rng[0]), .range_ch2(rng[1]));

   // free-running clock
   always #5 mclk = ~mclk;

   // hang guard, run needs about 1200 cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         n_mismatch++;
         complete_run();
      end
   end

   // compare and count
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // one register write, model copy follows
   task automatic reg_wr(input logic [7:0] a, input atc_pkg::atc_reg_t d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge mclk);
      reg_we <= 1'b0;
      if (a == 8'h0f) cfg = d;
      if (a == 8'h0b) setup[0] = d;
      if (a == 8'h0e) setup[1] = d;
   endtask

   // one register read, data sampled once settled
   task automatic reg_rd(input logic [7:0] a, output atc_pkg::atc_reg_t d);
      @(posedge mclk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge mclk);
      reg_re <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // readback of the map plus the decoded control outputs
   task automatic check_regs();
      reg_rd(8'h0f, rd);
      check("config", {8'h00, cfg}, {8'h00, rd});
      reg_rd(8'h0b, rd);
      check("setup1", {8'h00, setup[0]}, {8'h00, rd});
      reg_rd(8'h0e, rd);
      check("setup2", {8'h00, setup[1]}, {8'h00, rd});
      reg_rd(8'h0c, rd);
      check("unmapped", 16'h0000, {8'h00, rd});
      check("ctrl", {7'h00, cfg[4:0], setup[0][7:6], setup[1][7:6]},
            {7'h00, en1, en2, cmode, rng[0], rng[1]});
   endtask

   // expected detect level; hysteresis only while active, adaptive, not disabled
   function automatic bit exp_det(input bit a, input logic [7:0] cf, input bit hd,
                                  input int av, input int s, input int t, input int d);
      int lo;
      int hi;
      int h;
      lo = cf[7] ? t : av - s;
      hi = cf[7] ? t : av + s;
      h = (a && !cf[7] && !hd) ? s >> 2 : 0;
      case (cf[6:5])
         2'b00: return d < lo + h;
         2'b01: return d > hi - h;
         2'b10: return d > lo - h && d < hi + h;
         default: return d < lo + h || d > hi - h;
      endcase
   endfunction

   // one result; model updates only for an enabled channel
   task automatic conv(input bit ch, input atc_pkg::atc_data_t d);
      int av;
      av = int'(acc[ch] >>> 16);
      @(posedge mclk);
      conv_done <= 1'b1;
      conv_channel <= ch;
      conv_data <= d;
      @(posedge mclk);
      conv_done <= 1'b0;
      if (ch ? cfg[3] : cfg[4]) begin
         act[ch] = exp_det(act[ch], cfg, setup[ch][4], av, sens[ch], thr[ch], d);
         acc[ch] = seeded[ch] ? acc[ch] + (((longint'(d) <<< 16) - acc[ch])
                   >>> (setup[ch][3:0] + 1)) : longint'(d) <<< 16;
         seeded[ch] = 1'b1;
      end
      #1;
      check("average", acc[ch][31:16], avg[ch]);
      check("detect", {14'h0000, act[1], act[0]}, {14'h0000, detect_out});
   endtask

   initial begin
      seed = 72;
      mclk = 1'b0;
      rst = 1'b1;
      {reg_addr, reg_wdata, reg_we, reg_re, conv_done, conv_channel} = '0;
      conv_data = 16'h0000;
      sens = '{16'h0400, 16'h0200};
      thr = '{16'h6000, 16'h8000};
      cycles = 0;
      cfg = 8'h19;
      setup = '{8'h0b, 8'h0b};
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      #1 check("avg reset", 16'h0000, avg[0] | avg[1]);
      check_regs();
      // fixed mode first, so seeding results do not hang on a zero average
      reg_wr(8'h0f, 8'h99);
      conv(1'b0, 16'h5000);
      conv(1'b1, 16'h9000);
      // slowest settling on a result equal to the average: no drift allowed
      reg_wr(8'h0b, 8'h0f);
      conv(1'b0, 16'h5000);
      for (int i = 0; i < 400; i++) begin
         if (i % 16 == 0) begin
            k = i / 16;
            v = $random(seed);
            // every compare mode in both threshold modes, channels dropped late
            reg_wr(8'h0f, {k[2:0], (k >= 20) ? v[4:3] : 2'b11, v[2:0]});
            reg_wr(8'h0b, {v[15:14], 1'b0, k[3], v[11:8]});
            reg_wr(8'h0e, {v[23:22], 1'b0, ~k[3], v[19:16]});
            check_regs();
         end
         k = $random(seed) & 1;
         v = int'(acc[k] >>> 16) + $random(seed) % 5120;
         if (i % 8 == 0) v = 16'h4000 + ($random(seed) & 16'h7fff);
         sens[k] <= 16'($random(seed) & 16'h0fff);
         thr[k] <= 16'(int'(acc[k] >>> 16) + $random(seed) % 2048);
         conv(k[0], v[15:0]);
      end
      complete_run();
   end
endmodule

`default_nettype wire
